// ===== design/misc_gpio_params.svh
// Offsets, field positions, reset values and timing constants for the misc/gpio/dac block
`ifndef MISC_GPIO_PARAMS_SVH
`define MISC_GPIO_PARAMS_SVH

`define ADDR_DAC_LO        7'h30
`define ADDR_DAC_HI        7'h31
`define ADDR_PIN_LO        7'h32
`define ADDR_PIN_HI        7'h33
`define ADDR_MISC_LO       7'h34
`define ADDR_MISC_HI       7'h35
`define ADDR_ADC_LO        7'h12
`define ADDR_ADC_HI        7'h13

`define REG_RESET          16'h0000
`define DAC_WMASK          16'h0FFF
`define PIN_WMASK          16'h0303
`define MISC_WMASK         16'h0707
`define MISC_NV_MASK       16'h0407
`define ADC_MASK           16'h0FFF

`define MISC_SKIP_CHECK    10
`define MISC_REVERSE       9
`define MISC_CHECK_CONT    8
`define MISC_READY_EN      2
`define MISC_READY_POL     1
`define MISC_READY_SEL     0

`define PIN_LEVEL_LSB      8
`define PIN_DIR_LSB        0

`define CLK_HZ             20000000
`define SELF_CHECK_HP_MS   13
`define SELF_CHECK_LP_MS   35
`define SELF_CHECK_HP_CYC  (`SELF_CHECK_HP_MS * (`CLK_HZ / 1000))
`define SELF_CHECK_LP_CYC  (`SELF_CHECK_LP_MS * (`CLK_HZ / 1000))
`define CHECK_CNT_W        20

`endif

// ===== design/misc_gpio_pkg.sv
// Types shared by the misc/gpio/dac register block
package misc_gpio_pkg;

  typedef logic [15:0] reg16_t;
  typedef logic [1:0]  pin_pair_t;

  typedef enum logic [1:0] {
    SC_LOAD,
    SC_IDLE,
    SC_POWERUP,
    SC_CONT
  } self_check_state_t;

endpackage : misc_gpio_pkg

// ===== design/misc_control_gpio_dac_regs.sv
// Misc control, DAC code, ADC readback and two shared general-purpose pins
`timescale 1ns/1ps
`include "misc_gpio_params.svh"

module misc_control_gpio_dac_regs #(
  parameter int SELF_CHECK_HP_CYCLES = `SELF_CHECK_HP_CYC,
  parameter int SELF_CHECK_LP_CYCLES = `SELF_CHECK_LP_CYC
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic                   soft_reset,
  input  wire logic [6:0]             reg_addr,
  input  wire logic                   reg_wr_en,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_rd_en,
  output logic      [7:0]             reg_rdata,
  input  wire logic                   dac_latch,
  output logic      [11:0]            dac_code,
  input  wire logic [11:0]            adc_result,
  input  wire logic [2:0]             nv_ready_cfg,
  input  wire logic                   nv_skip_self_check,
  output misc_gpio_pkg::reg16_t       misc_control_value,
  input  wire logic                   low_power_mode,
  input  wire logic                   self_check_fail_in,
  output logic                        self_check_active,
  output logic                        sample_period_fast,
  output logic                        self_check_failed,
  output logic                        reverse_rotation,
  input  wire logic                   sample_done,
  input  wire logic                   conversion_mid,
  input  wire misc_gpio_pkg::pin_pair_t alarm_claim,
  input  wire misc_gpio_pkg::pin_pair_t alarm_level,
  input  wire misc_gpio_pkg::pin_pair_t pin_in,
  output misc_gpio_pkg::pin_pair_t    pin_out,
  output misc_gpio_pkg::pin_pair_t    pin_oe
);
  import misc_gpio_pkg::*;

  // Merge one written byte into a register, leaving unused bits at zero
  function automatic reg16_t byte_merge(input reg16_t old_val, input logic hi_byte,
                                        input logic [7:0] wdata, input reg16_t wmask);
    reg16_t merged;
    merged = old_val;
    if (hi_byte) begin
      merged[15:8] = wdata;
    end else begin
      merged[7:0] = wdata;
    end
    byte_merge = merged & wmask;
  endfunction : byte_merge

  reg16_t            dac_output_code;
  reg16_t            pin_direction_level;
  reg16_t            misc_control;
  self_check_state_t state;
  logic [`CHECK_CNT_W-1:0] check_cnt;
  logic              ready_level;

  reg16_t            next_dac_output_code;
  reg16_t            next_pin_direction_level;
  reg16_t            next_misc_control;
  self_check_state_t next_state;
  logic [`CHECK_CNT_W-1:0] next_check_cnt;
  logic              next_self_check_failed;
  pin_pair_t         next_pin_out;
  pin_pair_t         next_pin_oe;
  logic [7:0]        next_reg_rdata;

  // Address decode
  wire hit_dac   = (reg_addr == `ADDR_DAC_LO)  || (reg_addr == `ADDR_DAC_HI);
  wire hit_pin   = (reg_addr == `ADDR_PIN_LO)  || (reg_addr == `ADDR_PIN_HI);
  wire hit_misc  = (reg_addr == `ADDR_MISC_LO) || (reg_addr == `ADDR_MISC_HI);
  wire hit_adc   = (reg_addr == `ADDR_ADC_LO)  || (reg_addr == `ADDR_ADC_HI);
  wire wr_dac    = reg_wr_en && hit_dac;
  wire wr_pin    = reg_wr_en && hit_pin;
  wire wr_misc   = reg_wr_en && hit_misc;
  wire hi_byte   = reg_addr[0];

  // Ready config bits, continuous check and skip check bits
  wire ready_en  = misc_control[`MISC_READY_EN];
  wire ready_pol = misc_control[`MISC_READY_POL];
  wire ready_sel = misc_control[`MISC_READY_SEL];
  wire check_cont = misc_control[`MISC_CHECK_CONT];
  wire skip_check = misc_control[`MISC_SKIP_CHECK];

  // Power-up check length follows the power mode in force when the check starts
  // The count is loaded once, so a mode change during the check cannot stretch it
  wire [`CHECK_CNT_W-1:0] check_len = low_power_mode ? `CHECK_CNT_W'(SELF_CHECK_LP_CYCLES - 1)
                                                     : `CHECK_CNT_W'(SELF_CHECK_HP_CYCLES - 1);

  // Register writes; the storage image of the nonvolatile bits is loaded after any reset
  always_comb begin
    next_dac_output_code     = dac_output_code;
    next_pin_direction_level = pin_direction_level;
    next_misc_control        = misc_control;
    if (wr_dac) begin
      next_dac_output_code = byte_merge(dac_output_code, hi_byte, reg_wdata, `DAC_WMASK);
    end
    if (wr_pin) begin
      next_pin_direction_level = byte_merge(pin_direction_level, hi_byte, reg_wdata, `PIN_WMASK);
    end
    if (wr_misc) begin
      next_misc_control = byte_merge(misc_control, hi_byte, reg_wdata, `MISC_WMASK);
    end
    if (state == SC_LOAD) begin
      next_misc_control = `REG_RESET;
      next_misc_control[`MISC_READY_EN:`MISC_READY_SEL] = nv_ready_cfg;
      next_misc_control[`MISC_SKIP_CHECK] = nv_skip_self_check;
    end
  end

  // Self-check sequencer
  always_comb begin
    next_state             = state;
    next_check_cnt         = check_cnt;
    next_self_check_failed = self_check_failed;
    case (state)
      SC_LOAD: begin
        if (nv_skip_self_check) begin
          next_state = SC_IDLE;
        end else begin
          next_state     = SC_POWERUP;
          next_check_cnt = check_len;
        end
      end
      SC_POWERUP: begin
        if (check_cnt == '0) begin
          next_self_check_failed = self_check_fail_in;
          next_state             = check_cont ? SC_CONT : SC_IDLE;
        end else begin
          next_check_cnt = check_cnt - `CHECK_CNT_W'(1);
        end
      end
      SC_IDLE: begin
        if (check_cont) begin
          next_state = SC_CONT;
        end
      end
      SC_CONT: begin
        // Result follows the evaluator for as long as the check runs
        next_self_check_failed = self_check_fail_in;
        if (!check_cont) begin
          next_state = SC_IDLE;
        end
      end
      default: begin
        next_state = SC_IDLE;
      end
    endcase
  end

  // Pin resolution: ready output first, then alarm, then plain pin control
  wire [1:0] ready_claim = ready_en ? (ready_sel ? 2'b10 : 2'b01) : 2'b00;
  wire       ready_drive = ready_pol ? ready_level : ~ready_level;
  wire [1:0] sw_dir      = pin_direction_level[`PIN_DIR_LSB+1:`PIN_DIR_LSB];
  wire [1:0] sw_level    = pin_direction_level[`PIN_LEVEL_LSB+1:`PIN_LEVEL_LSB];

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (ready_claim[i]) begin
        next_pin_oe[i]  = 1'b1;
        next_pin_out[i] = ready_drive;
      end else if (alarm_claim[i]) begin
        next_pin_oe[i]  = 1'b1;
        next_pin_out[i] = alarm_level[i];
      end else begin
        next_pin_oe[i]  = sw_dir[i];
        next_pin_out[i] = sw_dir[i] & sw_level[i];
      end
    end
  end

  // Level bits of an input pin read the pin itself
  wire [1:0] level_view = (sw_level & sw_dir) | (pin_in & ~sw_dir);
  reg16_t    pin_view;
  assign pin_view = (pin_direction_level & ~16'h0300) | {6'h00, level_view, 8'h00};

  wire reg16_t adc_view = {4'h0, adc_result} & `ADC_MASK;

  // Read mux; unmapped addresses read zero
  // A write in the same cycle as a read shows up only on the following read
  wire reg16_t read_word = hit_dac  ? dac_output_code :
                           hit_pin  ? pin_view :
                           hit_misc ? misc_control :
                           hit_adc  ? adc_view : `REG_RESET;

  assign next_reg_rdata = reg_rd_en ? (hi_byte ? read_word[15:8] : read_word[7:0]) : reg_rdata;

  wire run_check = (next_state == SC_POWERUP) || (next_state == SC_CONT);

  // Software reset clears the volatile contents except the fail status and the ready level, and reloads the stored ones
  // DAC code register; the DAC itself only follows it on a latch
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dac_output_code <= `REG_RESET;
    end else if (soft_reset) begin
      dac_output_code <= `REG_RESET;
    end else begin
      dac_output_code <= next_dac_output_code;
    end
  end

  // Pin direction and level register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_direction_level <= `REG_RESET;
    end else if (soft_reset) begin
      pin_direction_level <= `REG_RESET;
    end else begin
      pin_direction_level <= next_pin_direction_level;
    end
  end

  // Misc control; cleared here, stored bits come back in the load cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      misc_control <= `REG_RESET;
    end else if (soft_reset) begin
      misc_control <= `REG_RESET;
    end else begin
      misc_control <= next_misc_control;
    end
  end

  // Sequencer state; any reset restarts from the load cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state     <= SC_LOAD;
      check_cnt <= '0;
    end else if (soft_reset) begin
      state     <= SC_LOAD;
      check_cnt <= '0;
    end else begin
      state     <= next_state;
      check_cnt <= next_check_cnt;
    end
  end

  // The fail status survives a software reset so the host can still see why it reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      self_check_failed <= 1'b0;
    end else if (!soft_reset) begin
      self_check_failed <= next_self_check_failed;
    end
  end

  // Sample-ready level: a new sample in the same cycle as the midway clear wins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ready_level <= 1'b0;
    end else if (sample_done) begin
      ready_level <= 1'b1;
    end else if (conversion_mid) begin
      ready_level <= 1'b0;
    end
  end

  // The DAC moves only on the latch command or a software reset, never on a byte write
  // A latch in the same cycle as a byte write takes the code from before that write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dac_code <= 12'h000;
    end else if (soft_reset) begin
      dac_code <= 12'h000;
    end else if (dac_latch) begin
      dac_code <= dac_output_code[11:0];
    end
  end

  // Outputs follow the software reset in its own cycle, not one cycle later
  wire         next_check_active = run_check & ~soft_reset;
  wire         next_reverse      = next_misc_control[`MISC_REVERSE] & ~soft_reset;
  wire reg16_t next_misc_value   = soft_reset ? `REG_RESET : next_misc_control;

  // Registered pin drive
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= 2'b00;
      pin_oe  <= 2'b00;
    end else begin
      pin_out <= next_pin_out;
      pin_oe  <= next_pin_oe;
    end
  end

  // Read byte holds until the next read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // Check status and rotation direction
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      self_check_active  <= 1'b0;
      sample_period_fast <= 1'b0;
      reverse_rotation   <= 1'b0;
    end else begin
      self_check_active  <= next_check_active;
      // Period override drops with the check, so the user setting returns untouched
      sample_period_fast <= next_check_active;
      reverse_rotation   <= next_reverse;
    end
  end

  // Copy for the store logic, always equal to the register itself
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      misc_control_value <= `REG_RESET;
    end else begin
      misc_control_value <= next_misc_value;
    end
  end

endmodule : misc_control_gpio_dac_regs

// ===== sim/misc_gpio_props.sv
// Port checks for the misc control, DAC and shared pin block
`timescale 1ns/1ps
module misc_gpio_props
  import misc_gpio_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        soft_reset,
  input wire logic [6:0]  reg_addr,
  input wire logic        reg_wr_en,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_rd_en,
  input wire logic [7:0]  reg_rdata,
  input wire logic        dac_latch,
  input wire logic [11:0] dac_code,
  input wire reg16_t      misc_control_value,
  input wire logic        self_check_active,
  input wire logic        sample_period_fast,
  input wire logic        sample_done,
  input wire logic        conversion_mid,
  input wire pin_pair_t   alarm_claim,
  input wire pin_pair_t   alarm_level,
  input wire pin_pair_t   pin_out,
  input wire pin_pair_t   pin_oe
);
  logic [11:0] dac_sh;
  logic [3:0]  pin_sh;
  wire logic   en  = misc_control_value[2];
  wire logic   sel = misc_control_value[0];
  wire logic   pol = misc_control_value[1];

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Mirror of the DAC and pin byte writes, so reads and latches are judged without the body
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dac_sh <= 12'h000;
      pin_sh <= 4'h0;
    end else if (soft_reset) begin
      dac_sh <= 12'h000;
      pin_sh <= 4'h0;
    end else if (reg_wr_en) begin
      case (reg_addr)
        7'h30: dac_sh[7:0] <= reg_wdata;
        7'h31: dac_sh[11:8] <= reg_wdata[3:0];
        7'h32: pin_sh[1:0] <= reg_wdata[1:0];
        7'h33: pin_sh[3:2] <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  dac_hold_a: assert property (!dac_latch && !soft_reset |=> $stable(dac_code))
    else $error("dac code moved");
  dac_latch_a: assert property (dac_latch && !soft_reset |=> dac_code == $past(dac_sh))
    else $error("dac latch wrong");
  dac_read_a: assert property (
    reg_rd_en && reg_addr == 7'h31 |=> reg_rdata == {4'h0, $past(dac_sh[11:8])})
    else $error("dac high read wrong");
  unmapped_read_a: assert property (
    reg_rd_en && !(reg_addr inside {[7'h30:7'h35], 7'h12, 7'h13}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  pin_soft_a: assert property (
    !en && alarm_claim == 2'b00 && !soft_reset ##1 !en
    |-> pin_oe == $past(pin_sh[1:0]) && pin_out == $past(pin_sh[3:2] & pin_sh[1:0]))
    else $error("pin control wrong");
  alarm_win_a: assert property (
    !en && alarm_claim[0] && !soft_reset ##1 !en |-> pin_oe[0] && pin_out[0] == $past(alarm_level[0]))
    else $error("alarm not driving pin");
  ready_set_a: assert property (
    en && sample_done && !soft_reset ##1 !soft_reset |-> ##1 pin_oe[sel] && pin_out[sel] == pol)
    else $error("ready not active");
  ready_clear_a: assert property (
    en && conversion_mid && !sample_done && !soft_reset ##1 !soft_reset |-> ##1 pin_out[sel] == !pol)
    else $error("ready not cleared");
  period_same_a: assert property (sample_period_fast == self_check_active)
    else $error("period override mismatch");
  cont_check_a: assert property (misc_control_value[8] && !soft_reset |=> self_check_active)
    else $error("continuous check not running");
endmodule : misc_gpio_props

bind misc_control_gpio_dac_regs misc_gpio_props i_props (
  .clk_sys, .rst_n, .soft_reset, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata,
  .dac_latch, .dac_code, .misc_control_value, .self_check_active, .sample_period_fast,
  .sample_done, .conversion_mid, .alarm_claim, .alarm_level, .pin_out, .pin_oe);

// ===== sim/host_model.sv
// Host side of the register port: byte accesses and the DAC latch
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] reg_rdata,
  output logic      [6:0] reg_addr,
  output logic            reg_wr_en,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd_en,
  output logic            dac_latch
);
  initial begin
    reg_addr = 7'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
    reg_rd_en = 1'b0;
    dac_latch = 1'b0;
  end

  // Idle address and data are inverted so a stale value never passes for a live one
  task automatic access(input logic [6:0] a, input logic [7:0] d, input logic w, output logic [7:0] q);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= w;
    reg_rd_en <= !w;
    @(posedge clk_sys);
    reg_addr <= ~a;
    reg_wdata <= ~d;
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b0;
    #1 q = reg_rdata;
  endtask : access

  task automatic dac_load(input logic [15:0] v);
    logic [7:0] q;
    access(7'h30, v[7:0], 1'b1, q);
    access(7'h31, v[15:8], 1'b1, q);
    @(posedge clk_sys);
    dac_latch <= 1'b1;
    @(posedge clk_sys);
    dac_latch <= 1'b0;
  endtask : dac_load
endmodule : host_model

// ===== sim/tb.sv
// Self-checking bench for the misc control, DAC and shared pin block
`timescale 1ns/1ps
module tb;
  import misc_gpio_pkg::*;
  localparam int HP = 20;
  logic        clk_sys = 1'b0, rst_n = 1'b0, soft_reset = 1'b0, sample_done = 1'b0, conversion_mid = 1'b0;
  logic        nv_skip_self_check = 1'b0, low_power_mode = 1'b0, self_check_fail_in = 1'b1;
  logic        reg_wr_en, reg_rd_en, dac_latch, self_check_active, sample_period_fast;
  logic        self_check_failed, reverse_rotation;
  logic [6:0]  reg_addr, a;
  logic [7:0]  reg_wdata, reg_rdata, q;
  logic [11:0] dac_code, adc_result = 12'h000;
  logic [2:0]  nv_ready_cfg = 3'b110;
  reg16_t      misc_control_value;
  pin_pair_t   alarm_claim = 2'b00, alarm_level = 2'b00, pin_in = 2'b00, pin_out, pin_oe;
  int          num_errors, comparisons, m_dac, m_pin, seed = 43285, m_misc = 'h0006;
  logic [6:0]  addrs [9] = '{7'h30, 7'h31, 7'h32, 7'h33, 7'h34, 7'h35, 7'h12, 7'h13, 7'h36};
  logic [15:0] dv [3] = '{16'h0FFF, 16'hFABC, 16'h0000};

  always #25 clk_sys = ~clk_sys;

  misc_control_gpio_dac_regs #(.SELF_CHECK_HP_CYCLES(HP), .SELF_CHECK_LP_CYCLES(2 * HP)) i_dut (
    .clk_sys, .rst_n, .soft_reset, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata,
    .dac_latch, .dac_code, .adc_result, .nv_ready_cfg, .nv_skip_self_check, .misc_control_value,
    .low_power_mode, .self_check_fail_in, .self_check_active, .sample_period_fast, .self_check_failed,
    .reverse_rotation, .sample_done, .conversion_mid, .alarm_claim, .alarm_level, .pin_in, .pin_out, .pin_oe);
  host_model i_host (.clk_sys, .reg_rdata, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .dac_latch);

  task automatic complete_run();
    if (num_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic wr(input logic [6:0] wa, input logic [7:0] d);
    i_host.access(wa, d, 1'b1, q);
    case (wa)
      7'h30: m_dac[7:0] = d;
      7'h31: m_dac[15:8] = d & 8'h0F;
      7'h32: m_pin[7:0] = d & 8'h03;
      7'h33: m_pin[15:8] = d & 8'h03;
      7'h34: m_misc[7:0] = d & 8'h07;
      7'h35: m_misc[15:8] = d & 8'h07;
      default: ;
    endcase
  endtask : wr

  // Input pins read their own level, output pins the level written
  task automatic rdchk(input logic [6:0] ra);
    int v;
    i_host.access(ra, 8'h00, 1'b0, q);
    case (ra)
      7'h30, 7'h31: v = m_dac;
      7'h32, 7'h33: v = (m_pin & 3) | ((((m_pin >> 8) & m_pin) | (pin_in & ~m_pin)) & 3) << 8;
      7'h34, 7'h35: v = m_misc;
      7'h12, 7'h13: v = adc_result;
      default: v = 0;
    endcase
    chk(q, ra[0] ? v[15:8] : v[7:0]);
  endtask : rdchk

  task automatic pulse(input logic mid);
    @(posedge clk_sys);
    sample_done <= !mid;
    conversion_mid <= mid;
    @(posedge clk_sys);
    sample_done <= 1'b0;
    conversion_mid <= 1'b0;
    tick(1);
  endtask : pulse

  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    tick(1);
    chk(self_check_active, 1);
    tick(HP - 2);
    for (int i = 0; self_check_active === 1'b1; i++) begin
      if (i == 10) begin
        num_errors++;
        complete_run();
      end
      tick(1);
    end
    chk(self_check_failed, 1);
    foreach (addrs[i]) rdchk(addrs[i]);
    for (int i = 0; i < 30; i++) begin
      @(posedge clk_sys);
      adc_result <= 12'($random(seed));
      pin_in <= 2'($random(seed));
      a = addrs[{$random(seed)} % 9];
      wr(a, 8'($random(seed)));
      rdchk(a);
    end
    chk(dac_code, 0);
    foreach (dv[i]) begin
      i_host.dac_load(dv[i]);
      m_dac = dv[i] & 'h0FFF;
      #1 chk(dac_code, m_dac);
    end
    wr(7'h34, 8'h00);
    wr(7'h35, 8'h00);
    wr(7'h32, 8'h01);
    wr(7'h33, 8'h02);
    tick(2);
    chk({pin_oe, pin_out}, 4'b0100);
    @(posedge clk_sys);
    alarm_claim <= 2'b01;
    alarm_level <= 2'b11;
    tick(3);
    chk({pin_oe, pin_out}, 4'b0101);
    wr(7'h34, 8'h05);
    tick(2);
    chk({pin_oe, pin_out}, 4'b1111);
    pulse(1'b0);
    chk(pin_out, 2'b01);
    pulse(1'b1);
    chk(pin_out, 2'b11);
    wr(7'h34, 8'h06);
    tick(2);
    chk({pin_oe, pin_out}, 4'b0100);
    pulse(1'b0);
    chk(pin_out, 2'b01);
    wr(7'h35, 8'h02);
    tick(2);
    chk(reverse_rotation, 1);
    wr(7'h35, 8'h01);
    tick(3);
    chk({reverse_rotation, self_check_active, sample_period_fast}, 3'b011);
    @(posedge clk_sys);
    nv_ready_cfg <= 3'b101;
    nv_skip_self_check <= 1'b1;
    soft_reset <= 1'b1;
    @(posedge clk_sys);
    soft_reset <= 1'b0;
    tick(2);
    m_dac = 0;
    m_pin = 0;
    m_misc = 'h0405;
    chk({dac_code, self_check_active, self_check_failed}, 14'h0001);
    foreach (addrs[i]) rdchk(addrs[i]);
    complete_run();
  end
endmodule : tb
